// >>> shared/dsm_pkg.sv
// Purpose: Constants and types for the digitizer setup memory block
// Assumes: Byte-wide dataway commands decoded into function and subaddress
// Notes:   Setup addresses follow the readback order of the setup memory
`default_nettype none
package dsm_pkg;
    // Dataway function codes
    localparam logic [4:0] DSM_F_ADDR16 = 5'h00;
    localparam logic [4:0] DSM_F_ADDR17 = 5'h01;
    localparam logic [4:0] DSM_F_READ   = 5'h02;
    localparam logic [4:0] DSM_F_ADDR19 = 5'h03;
    localparam logic [4:0] DSM_F_LOCKT  = 5'h0b;
    localparam logic [4:0] DSM_F_WR16   = 5'h10;
    localparam logic [4:0] DSM_F_WR17   = 5'h11;
    localparam logic [4:0] DSM_F_PREP   = 5'h12;
    localparam logic [4:0] DSM_F_WR19   = 5'h13;
    // Subaddresses
    localparam logic [3:0] DSM_A_READ   = 4'h1;
    localparam logic [3:0] DSM_A_BLKWR  = 4'h1;
    localparam logic [3:0] DSM_A_MEMSZ  = 4'h2;
    localparam logic [3:0] DSM_A_SETUP  = 4'h0;
    localparam logic [3:0] DSM_A_VERIFY = 4'h6;
    localparam logic [3:0] DSM_A_DIAG   = 4'h7;
    localparam logic [3:0] DSM_A_TRIGAD = 4'ha;
    // Setup memory layout
    localparam int         DSM_AW          = 12;
    localparam logic [11:0] DSM_BASE16     = 12'h000;
    localparam logic [11:0] DSM_BASE17     = 12'h010;
    localparam logic [11:0] DSM_ADR_MEMSZ  = 12'h020;
    localparam logic [11:0] DSM_ADR_FIRST  = 12'h001;
    localparam logic [11:0] DSM_ADR_TRIG   = 12'h400;
    localparam logic [11:0] DSM_ADR_DIAG   = 12'h024;
    localparam logic [11:0] DSM_ADR_STATUS = 12'h021;
    localparam logic [11:0] DSM_ADR_LEDS   = 12'h023;
    // Offsets inside the blocks written by the F17 group and, for TRSRC, NEARLO and NEARHI, the F16 group
    localparam logic [3:0] DSM_O_NCH    = 4'h0;
    localparam logic [3:0] DSM_O_OFS1   = 4'h1;
    localparam logic [3:0] DSM_O_SRC1   = 4'h5;
    localparam logic [3:0] DSM_O_DELAY  = 4'h9;
    localparam logic [3:0] DSM_O_SEGLEN = 4'ha;
    localparam logic [3:0] DSM_O_SEGLO  = 4'hb;
    localparam logic [3:0] DSM_O_SEGHI  = 4'hc;
    localparam logic [3:0] DSM_O_DUAL   = 4'hd;
    localparam logic [3:0] DSM_O_CLK1   = 4'he;
    localparam logic [3:0] DSM_O_CLK2   = 4'hf;
    localparam logic [3:0] DSM_O_TRSRC  = 4'hd;
    localparam logic [3:0] DSM_O_NEARLO = 4'he;
    localparam logic [3:0] DSM_O_NEARHI = 4'hf;
    // Decoding constants
    localparam logic [7:0] DSM_OFS_ZERO   = 8'h80;
    localparam logic [7:0] DSM_DELAY_BIAS = 8'h08;
    localparam logic [7:0] DSM_IRAM_ERR   = 8'hff;
    localparam logic [7:0] DSM_CLK_EXT    = 8'h00;
    localparam logic [7:0] DSM_CLK_2MHZ   = 8'h10;
    localparam logic [7:0] DSM_CLK_5MHZ   = 8'h11;
    localparam logic [7:0] DSM_SEG_MAX    = 8'h0d;
    localparam logic [15:0] DSM_SEGCNT_MAX = 16'h0400;
    localparam logic [7:0] DSM_LED_OK     = 8'h10;
    localparam logic [3:0] DSM_SEG_BASE   = 4'ha;
    localparam logic [4:0] DSM_MEM_UNIT   = 5'h13;
    localparam int         DSM_DIAG_CYC   = 64;

    typedef enum logic [1:0]
    {
        DSM_TRIG_EXT  = 2'b00,
        DSM_TRIG_CH1  = 2'b01,
        DSM_TRIG_CH2  = 2'b10,
        DSM_TRIG_SOFT = 2'b11
    } dsm_trig_type;

    typedef enum logic [1:0]
    {
        DSM_IN_NONINV = 2'b00,
        DSM_IN_INV    = 2'b01,
        DSM_IN_DIFF   = 2'b10,
        DSM_IN_GND    = 2'b11
    } dsm_input_type;

    typedef enum logic [1:0]
    {
        DSM_TB_PRIMARY   = 2'b00,
        DSM_TB_SECONDARY = 2'b01,
        DSM_TB_EXTERNAL  = 2'b10
    } dsm_tb_type;

    typedef struct packed
    {
        logic [4:0] func;
        logic [3:0] sub;
        logic [7:0] wdata;
    } dsm_cmd_type;

    typedef struct packed
    {
        dsm_input_type src;
        logic          ac;
        logic [7:0]    offset_signed;
    } dsm_chan_type;

    typedef struct packed
    {
        dsm_trig_type trig_src;
        logic         soft_trig_only;
        logic [15:0]  near_count;
        logic [2:0]   channels;
        logic         chan_ok;
        logic signed [8:0] delay_eighths;
        logic         stop_at_trig;
        logic [8:0]   collect_segs;
        logic [23:0]  seg_len;
        logic         seg_len_ok;
        logic [15:0]  seg_count;
        dsm_tb_type   tb_pre;
        dsm_tb_type   tb_near;
        dsm_tb_type   tb_far;
        logic [7:0]   clk1_code;
        logic [7:0]   clk2_code;
        logic         clk1_ok;
        logic         clk2_ok;
        logic [4:0]   mem_units;
    } dsm_cfg_type;
endpackage
`default_nettype wire

// >>> design/dsm_ram.sv
// Purpose: Dual-ported byte memory holding setup and trigger addresses
// Assumes: One write port and two read ports on one clock
// Notes:   Battery backing is outside; contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module dsm_ram
    import dsm_pkg::*;
#(
    parameter int AW = DSM_AW
)
(
    input  wire logic          clock_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o,
    input  wire logic [AW-1:0] caddr_i,
    output logic      [7:0]    cdata_o
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Readback port and combinational setup tap
    always_ff @(posedge clock_i)
    begin
        rdata_o <= mem[raddr_i];
    end

    assign cdata_o = mem[caddr_i];
endmodule
`default_nettype wire

// >>> design/dsm_setup_bank.sv
// Purpose: Setup register bank of a four-channel digitizer
// Assumes: Dataway strobe is a one-cycle pulse from the same clock domain
// Notes:   Setup is latched into the working copy on arm or verify
//
// Functional notes
// - Trigger source: external, ch1, ch2, software
// - Channel count codes 1,2,4 limit rates
// - Offset byte is offset binary, 128 zero
// - Input code: polarity pair, even DC, odd AC
// - Trigger delay signed eighths, -8 to +247
// - Delay sets stop, start, or collected segments
// - Segment length is 1024 shifted by code
// - Length code 13 one channel, 12 two
// - Segment count 1 to 1024, one per trigger
// - Dual mode picks clocks for near and far parts, pre stays primary
// - Primary clock code 0 external, 16/17 limited
// - External primary ignores dual mode, secondary
// - Secondary clock code 0 invalid
// - Diagnostic keeps setup, status on RAM pass
// - Diagnostic report of six readback bytes
// - Internal RAM error byte is always 255
// - Block write stores byte, advances address
// - Memory code counts 512k word units
// - Low data byte saved and read back
// - Verify lowers segment count to fit memory
`timescale 1ns/1ps
`default_nettype none
module dsm_setup_bank
    import dsm_pkg::*;
#(
    parameter int          DIAG_CYCLES = DSM_DIAG_CYC,
    parameter logic [15:0] ROM_SUM     = 16'h0000
)
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        strobe_i,
    input  wire dsm_cmd_type cmd_i,
    input  wire logic        arm_i,
    input  wire logic        dpram_fault_i,
    output logic [7:0]       rdata_o,
    output logic             q_o,
    output logic             lockout_o,
    output logic             status_ok_o,
    output dsm_cfg_type      cfg_o,
    output dsm_chan_type [3:0] chan_o
);
    // ==========================================================
    // Decode helpers
    // ==========================================================
    function automatic logic is_cmd(input dsm_cmd_type c, input logic [4:0] f, input logic [3:0] a);
        return (c.func == f) && (c.sub == a);
    endfunction

    function automatic logic clk_legal(input logic [7:0] code, input logic [2:0] nch, input logic zero_ok);
        logic ok;
        ok = (code <= DSM_CLK_5MHZ);
        if (code == DSM_CLK_EXT && !zero_ok)
            ok = 1'b0;
        if (code == DSM_CLK_2MHZ && nch > 3'd2)
            ok = 1'b0;
        if (code == DSM_CLK_5MHZ && nch != 3'd1)
            ok = 1'b0;
        return ok;
    endfunction

    function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    typedef enum logic [2:0]
    {
        DSM_ST_IDLE = 3'b000,
        DSM_ST_LOAD = 3'b001,
        DSM_ST_FIT  = 3'b010,
        DSM_ST_DIAG = 3'b011,
        DSM_ST_RPT  = 3'b100
    } dsm_state_type;

    // ==========================================================
    // Setup memory
    // ==========================================================
    logic [11:0]   rd_addr;
    logic [11:0]   wr_addr;
    logic [7:0]    wr_data;
    logic          wr_en;
    logic [11:0]   cfg_addr;
    logic [7:0]    cfg_byte;
    logic [7:0]    ram_rdata;
    dsm_state_type state;
    logic [5:0]    load_idx;
    logic [2:0]    rpt_idx;
    logic [15:0]   diag_cnt;
    logic [7:0]    setup_img [0:DSM_ADR_MEMSZ];
    logic [15:0]   seg_fit;
    logic          verify_req;
    logic          busy;

    dsm_ram #(.AW(DSM_AW)) u_ram
    (
        .clock_i (clock_i),
        .we_i    (wr_en),
        .waddr_i (wr_addr),
        .wdata_i (wr_data),
        .raddr_i (rd_addr),
        .rdata_o (ram_rdata),
        .caddr_i (cfg_addr),
        .cdata_o (cfg_byte)
    );

    assign busy      = (state != DSM_ST_IDLE);
    assign lockout_o = busy;
    assign verify_req = (strobe_i && is_cmd(cmd_i, DSM_F_PREP, DSM_A_VERIFY)) || arm_i;

    // ==========================================================
    // Dataway write and readback path
    // ==========================================================
    logic host_wr;
    logic [11:0] host_waddr;

    always_comb
    begin
        host_wr    = 1'b0;
        host_waddr = rd_addr;
        if (strobe_i && !busy)
        begin
            if (cmd_i.func == DSM_F_WR16)
            begin
                host_wr    = 1'b1;
                host_waddr = DSM_BASE16 + {8'h00, cmd_i.sub};
            end
            else if (cmd_i.func == DSM_F_WR17)
            begin
                host_wr    = 1'b1;
                host_waddr = DSM_BASE17 + {8'h00, cmd_i.sub};
            end
            else if (is_cmd(cmd_i, DSM_F_WR19, DSM_A_MEMSZ))
            begin
                host_wr    = 1'b1;
                host_waddr = DSM_ADR_MEMSZ;
            end
            else if (is_cmd(cmd_i, DSM_F_WR19, DSM_A_BLKWR))
            begin
                host_wr    = 1'b1;
                host_waddr = rd_addr;
            end
        end
    end

    // Diagnostic report writes use the same port
    logic [7:0] rpt_byte;

    always_comb
    begin
        case (rpt_idx)
            3'd0:    rpt_byte = {7'h00, dpram_fault_i};
            3'd1:    rpt_byte = {7'h00, dpram_fault_i};
            3'd2:    rpt_byte = {7'h00, dpram_fault_i};
            3'd3:    rpt_byte = ROM_SUM[15:8];
            3'd4:    rpt_byte = ROM_SUM[7:0];
            default: rpt_byte = DSM_IRAM_ERR;
        endcase
    end

    always_comb
    begin
        if (state == DSM_ST_RPT)
        begin
            wr_en   = 1'b1;
            wr_addr = DSM_ADR_DIAG + {9'h000, rpt_idx};
            wr_data = rpt_byte;
        end
        else if (state == DSM_ST_FIT)
        begin
            wr_en   = 1'b1;
            wr_addr = DSM_BASE17 + {8'h00, DSM_O_SEGLO};
            wr_data = seg_fit[7:0];
        end
        else
        begin
            wr_en   = host_wr;
            wr_addr = host_waddr;
            wr_data = cmd_i.wdata;
        end
    end

    // Readback address counter
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            rd_addr <= DSM_ADR_FIRST;
        else if (strobe_i && !busy)
        begin
            if (cmd_i.func == DSM_F_ADDR16)
                rd_addr <= DSM_BASE16 + {8'h00, cmd_i.sub};
            else if (cmd_i.func == DSM_F_ADDR17)
                rd_addr <= DSM_BASE17 + {8'h00, cmd_i.sub};
            else if (is_cmd(cmd_i, DSM_F_ADDR19, DSM_A_MEMSZ))
                rd_addr <= DSM_ADR_MEMSZ;
            else if (is_cmd(cmd_i, DSM_F_PREP, DSM_A_SETUP))
                rd_addr <= DSM_ADR_FIRST;
            else if (is_cmd(cmd_i, DSM_F_PREP, DSM_A_TRIGAD))
                rd_addr <= DSM_ADR_TRIG;
            else if (is_cmd(cmd_i, DSM_F_READ, DSM_A_READ) || is_cmd(cmd_i, DSM_F_WR19, DSM_A_BLKWR))
                rd_addr <= rd_addr + 12'h001;
        end
        else if (state == DSM_ST_RPT)
            rd_addr <= DSM_ADR_DIAG;
    end

    assign rdata_o = ram_rdata;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            q_o <= 1'b0;
        else
            q_o <= strobe_i && !busy;
    end

    // ==========================================================
    // Verify, fit and diagnostic sequencer
    // ==========================================================
    logic [7:0]  nch_code;
    logic [7:0]  mem_code;
    logic [31:0] seg_words;
    logic [31:0] mem_words;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state    <= DSM_ST_IDLE;
            load_idx <= 6'h00;
            rpt_idx  <= 3'h0;
            diag_cnt <= 16'h0000;
        end
        else
        begin
            case (state)
                DSM_ST_IDLE:
                begin
                    load_idx <= 6'h00;
                    rpt_idx  <= 3'h0;
                    diag_cnt <= 16'h0000;
                    if (verify_req)
                        state <= DSM_ST_LOAD;
                    else if (strobe_i && is_cmd(cmd_i, DSM_F_PREP, DSM_A_DIAG))
                        state <= DSM_ST_DIAG;
                end
                DSM_ST_LOAD:
                begin
                    load_idx <= load_idx + 6'h01;
                    if (load_idx == DSM_ADR_MEMSZ[5:0])
                        state <= DSM_ST_FIT;
                end
                DSM_ST_FIT:
                    state <= DSM_ST_IDLE;
                DSM_ST_DIAG:
                begin
                    diag_cnt <= diag_cnt + 16'h0001;
                    if (diag_cnt == 16'(DIAG_CYCLES - 1))
                        state <= DSM_ST_RPT;
                end
                DSM_ST_RPT:
                begin
                    rpt_idx <= rpt_idx + 3'h1;
                    if (rpt_idx == 3'h5)
                        state <= DSM_ST_IDLE;
                end
                default:
                    state <= DSM_ST_IDLE;
            endcase
        end
    end

    assign cfg_addr = DSM_BASE16 + {6'h00, load_idx};

    always_ff @(posedge clock_i)
    begin
        if (state == DSM_ST_LOAD)
            setup_img[load_idx] <= cfg_byte;
    end

    // Status indicator follows the dual-ported RAM test
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            status_ok_o <= 1'b0;
        else if (state == DSM_ST_DIAG && diag_cnt == 16'(DIAG_CYCLES - 1))
            status_ok_o <= !dpram_fault_i;
    end

    // ==========================================================
    // Working configuration decode
    // ==========================================================
    function automatic logic [7:0] img(input logic [11:0] base, input logic [3:0] ofs);
        logic [11:0] a;
        a = base + {8'h00, ofs};
        return setup_img[a[4:0]];
    endfunction

    logic [15:0] seg_req;
    logic [7:0]  len_code;
    logic [7:0]  dual_code;
    logic [7:0]  delay_code;
    logic [23:0] len_words;

    always_comb
    begin
        seg_req    = join16(img(DSM_BASE17, DSM_O_SEGHI), img(DSM_BASE17, DSM_O_SEGLO));
        len_code   = img(DSM_BASE17, DSM_O_SEGLEN);
        dual_code  = img(DSM_BASE17, DSM_O_DUAL);
        delay_code = img(DSM_BASE17, DSM_O_DELAY);
        nch_code   = img(DSM_BASE17, DSM_O_NCH);
        mem_code   = setup_img[DSM_ADR_MEMSZ[5:0]];
        len_words  = 24'h000001 << ({1'b0, len_code[3:0]} + {1'b0, DSM_SEG_BASE});
        seg_words  = {8'h00, len_words} * {29'h0, nch_code[2:0]};
        mem_words  = 32'({27'h0, mem_code[4:0]}) << DSM_MEM_UNIT;
        seg_fit    = seg_req;
        if (seg_fit > DSM_SEGCNT_MAX)
            seg_fit = DSM_SEGCNT_MAX;
        if (seg_fit == 16'h0000)
            seg_fit = 16'h0001;
        // Shrink count, never length, when memory is declared
        if (mem_code != 8'h00 && seg_words != 32'h0)
        begin
            if ((48'(seg_fit) * 48'(seg_words)) > 48'(mem_words))
                seg_fit = 16'(mem_words / seg_words);
            if (seg_fit == 16'h0000)
                seg_fit = 16'h0001;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            cfg_o <= '0;
        else if (state == DSM_ST_FIT)
        begin
            cfg_o.trig_src       <= dsm_trig_type'(2'(img(DSM_BASE16, DSM_O_TRSRC)));
            cfg_o.soft_trig_only <= (img(DSM_BASE16, DSM_O_TRSRC) & 8'h03) == 8'h03;
            cfg_o.near_count     <= join16(img(DSM_BASE16, DSM_O_NEARHI), img(DSM_BASE16, DSM_O_NEARLO));
            cfg_o.channels       <= nch_code[2:0];
            cfg_o.chan_ok        <= img(DSM_BASE17, DSM_O_NCH) inside {8'h01, 8'h02, 8'h04};
            cfg_o.delay_eighths  <= $signed({1'b0, delay_code}) - $signed({1'b0, DSM_DELAY_BIAS});
            cfg_o.stop_at_trig   <= (delay_code == 8'h00);
            cfg_o.collect_segs   <= ({1'b0, delay_code} + 9'h007) >> 3;
            cfg_o.seg_len        <= len_words;
            cfg_o.seg_len_ok     <= (len_code <= DSM_SEG_MAX)
                                    && !(len_code == DSM_SEG_MAX && img(DSM_BASE17, DSM_O_NCH) != 8'h01)
                                    && !(len_code == 8'h0c && img(DSM_BASE17, DSM_O_NCH) > 8'h02);
            cfg_o.seg_count      <= seg_fit;
            cfg_o.clk1_code      <= img(DSM_BASE17, DSM_O_CLK1);
            cfg_o.clk2_code      <= img(DSM_BASE17, DSM_O_CLK2);
            cfg_o.clk1_ok        <= clk_legal(img(DSM_BASE17, DSM_O_CLK1), nch_code[2:0], 1'b1);
            cfg_o.clk2_ok        <= clk_legal(img(DSM_BASE17, DSM_O_CLK2), nch_code[2:0], 1'b0);
            cfg_o.mem_units      <= mem_code[4:0];
            if (img(DSM_BASE17, DSM_O_CLK1) == DSM_CLK_EXT)
            begin
                cfg_o.tb_pre  <= DSM_TB_EXTERNAL;
                cfg_o.tb_near <= DSM_TB_EXTERNAL;
                cfg_o.tb_far  <= DSM_TB_EXTERNAL;
            end
            else
            begin
                cfg_o.tb_pre <= DSM_TB_PRIMARY;
                case (dual_code)
                    8'h01:
                    begin
                        cfg_o.tb_near <= DSM_TB_SECONDARY;
                        cfg_o.tb_far  <= DSM_TB_PRIMARY;
                    end
                    8'h02:
                    begin
                        cfg_o.tb_near <= DSM_TB_SECONDARY;
                        cfg_o.tb_far  <= DSM_TB_SECONDARY;
                    end
                    8'h03:
                    begin
                        cfg_o.tb_near <= DSM_TB_PRIMARY;
                        cfg_o.tb_far  <= DSM_TB_SECONDARY;
                    end
                    default:
                    begin
                        cfg_o.tb_near <= DSM_TB_PRIMARY;
                        cfg_o.tb_far  <= DSM_TB_PRIMARY;
                    end
                endcase
            end
        end
    end

    // Per-channel offset and input decode
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            chan_o <= '0;
        else if (state == DSM_ST_FIT)
        begin
            for (int c = 0; c < 4; c++)
            begin
                chan_o[c].src           <= dsm_input_type'(2'(img(DSM_BASE17, DSM_O_SRC1 + 4'(c)) >> 1));
                chan_o[c].ac            <= 1'(img(DSM_BASE17, DSM_O_SRC1 + 4'(c)));
                chan_o[c].offset_signed <= img(DSM_BASE17, DSM_O_OFS1 + 4'(c)) - DSM_OFS_ZERO;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/dsm_setup_bank_properties.sv
// Purpose: Port checks for the setup bank
// Assumes: One clock, synchronous reset
// Notes:   Bound to every instance
`timescale 1ns/1ps
`default_nettype none
module dsm_setup_bank_properties
    import dsm_pkg::*;
#(
    parameter int          DIAG_CYCLES = DSM_DIAG_CYC,
    parameter logic [15:0] ROM_SUM     = 16'h0000
)
(
    input wire logic               clock_i,
    input wire logic               sys_rst_i,
    input wire logic               strobe_i,
    input wire dsm_cmd_type        cmd_i,
    input wire logic               arm_i,
    input wire logic               dpram_fault_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               q_o,
    input wire logic               lockout_o,
    input wire logic               status_ok_o,
    input wire dsm_cfg_type        cfg_o,
    input wire dsm_chan_type [3:0] chan_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Loaded working copy has a nonzero length unless the length code's low nibble is 14 or 15
    wire logic ld = cfg_o.seg_len != 24'h0;
    property p_ack; strobe_i && !lockout_o |=> q_o; endproperty
    a_ack: assert property (p_ack) else $error("no q after strobe");
    property p_ref; strobe_i && lockout_o |=> !q_o; endproperty
    a_ref: assert property (p_ref) else $error("q during lockout");
    property p_hold; !lockout_o && $past(lockout_o) == 1'b0 |-> $stable(cfg_o); endproperty
    a_hold: assert property (p_hold) else $error("cfg moved when idle");
    property p_soft; ld |-> cfg_o.soft_trig_only == (cfg_o.trig_src == DSM_TRIG_SOFT); endproperty
    a_soft: assert property (p_soft) else $error("soft trigger flag");
    property p_ext;
        ld && cfg_o.clk1_code == DSM_CLK_EXT |-> cfg_o.tb_pre == DSM_TB_EXTERNAL
            && cfg_o.tb_near == DSM_TB_EXTERNAL && cfg_o.tb_far == DSM_TB_EXTERNAL;
    endproperty
    a_ext: assert property (p_ext) else $error("external clock ignored");
    property p_clk2; ld && cfg_o.clk2_code == 8'h00 |-> !cfg_o.clk2_ok; endproperty
    a_clk2: assert property (p_clk2) else $error("secondary code 0 ok");
    property p_seg; ld |-> $onehot(cfg_o.seg_len) && cfg_o.seg_len[9:0] == 10'h000; endproperty
    a_seg: assert property (p_seg) else $error("segment length shape");
    property p_stop; ld |-> cfg_o.stop_at_trig == (cfg_o.delay_eighths == -9'sd8); endproperty
    a_stop: assert property (p_stop) else $error("stop at trigger");
    property p_stat; $rose(status_ok_o) |-> !$past(dpram_fault_i); endproperty
    a_stat: assert property (p_stat) else $error("status despite fault");
endmodule
bind dsm_setup_bank dsm_setup_bank_properties #(.DIAG_CYCLES(DIAG_CYCLES), .ROM_SUM(ROM_SUM))
    dsm_setup_bank_properties_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .strobe_i(strobe_i),
    .cmd_i(cmd_i), .arm_i(arm_i), .dpram_fault_i(dpram_fault_i), .rdata_o(rdata_o), .q_o(q_o),
    .lockout_o(lockout_o), .status_ok_o(status_ok_o), .cfg_o(cfg_o), .chan_o(chan_o));
`default_nettype wire

// >>> dv/dsm_ctrl_model.sv
// Purpose: Crate controller model issuing byte commands
// Assumes: Commands launched at the falling edge
// Notes:   Released command lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module dsm_ctrl_model
    import dsm_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         lockout_i,
    output var  logic         strobe_o,
    output var  dsm_cmd_type  cmd_o
);
    initial
    begin
        strobe_o = 1'b0;
        cmd_o    = '0;
    end
    task automatic issue(input logic [4:0] f, input logic [3:0] a, input logic [7:0] w);
        @(negedge clock_i);
        strobe_o = 1'b1;
        cmd_o    = '{f, a, w};
        @(negedge clock_i);
        strobe_o = 1'b0;
        cmd_o    = ~cmd_o;
    endtask
    task automatic wait_free(output logic ok);
        for (int i = 0; i < 500 && lockout_i !== 1'b0; i++) @(negedge clock_i);
        ok = lockout_i === 1'b0;
    endtask
    task automatic timing(input logic [15:0] n, input logic [7:0] d, input logic [7:0] c1, input logic [7:0] c2);
        if (n < 16'h0004) n = 16'h0004;
        if (n > 16'hfffe) n = 16'hfffe;
        if (c1 >= DSM_CLK_2MHZ && c2 >= DSM_CLK_2MHZ) c2 = 8'h0f;
        issue(DSM_F_WR16, DSM_O_NEARLO, n[7:0]);
        issue(DSM_F_WR16, DSM_O_NEARHI, n[15:8]);
        issue(DSM_F_WR17, DSM_O_DUAL, d);
        issue(DSM_F_WR17, DSM_O_CLK1, c1);
        issue(DSM_F_WR17, DSM_O_CLK2, c2);
    endtask
endmodule
`default_nettype wire

// >>> dv/digitizer_setup_memory_tb_top.sv
// Purpose: Self-checking bench for the setup bank
// Assumes: Inputs driven at the falling edge
// Notes:   Short diagnostic count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module digitizer_setup_memory_tb_top;
    import dsm_pkg::*;
    logic               clock_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic               arm_i = 1'b0;
    logic               dpram_fault_i = 1'b0;
    logic               strobe_i;
    dsm_cmd_type        cmd_i;
    logic [7:0]         rdata_o;
    logic               q_o;
    logic               lockout_o;
    logic               status_ok_o;
    dsm_cfg_type        cfg_o;
    dsm_chan_type [3:0] chan_o;
    logic [7:0]         regs [16];
    logic               ok;
    int                 miscompares = 0;
    int                 n_tests = 0;
    always #5 clock_i = ~clock_i;
    dsm_setup_bank #(.DIAG_CYCLES(4), .ROM_SUM(16'h5a3c)) dsm_setup_bank_i (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .strobe_i(strobe_i), .cmd_i(cmd_i), .arm_i(arm_i), .dpram_fault_i(dpram_fault_i),
        .rdata_o(rdata_o), .q_o(q_o), .lockout_o(lockout_o), .status_ok_o(status_ok_o), .cfg_o(cfg_o), .chan_o(chan_o));
    dsm_ctrl_model dsm_ctrl_model_i (.clock_i(clock_i), .lockout_i(lockout_o), .strobe_o(strobe_i), .cmd_o(cmd_i));
    function automatic logic [23:0] seg_len(input logic [7:0] c);
        return 24'h000400 << c;
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] e);
        repeat (2) @(negedge clock_i);
        check(nm, {24'h0, e}, {24'h0, rdata_o});
        dsm_ctrl_model_i.issue(DSM_F_READ, DSM_A_READ, 8'h00);
    endtask
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end
    // ==========================================
    // Setup, readback, arm, diagnostics
    initial
    begin
        void'($urandom(17));
        repeat (8) @(negedge clock_i);
        sys_rst_i = 1'b0;
        foreach (regs[i]) regs[i] = 8'($urandom());
        regs[0] = 8'h01;
        regs[9] = 8'h00;
        regs[10] = 8'($urandom_range(11));
        regs[12] = 8'h00;
        regs[13] = 8'($urandom_range(3));
        regs[14] = DSM_CLK_EXT;
        regs[15] = 8'h00;
        for (int i = 0; i < 13; i++) dsm_ctrl_model_i.issue(DSM_F_WR17, 4'(i), regs[i]);
        dsm_ctrl_model_i.issue(DSM_F_WR16, DSM_O_TRSRC, 8'h03);
        dsm_ctrl_model_i.timing(16'h012c, regs[13], regs[14], regs[15]);
        dsm_ctrl_model_i.issue(DSM_F_WR19, DSM_A_MEMSZ, 8'h00);
        dsm_ctrl_model_i.issue(DSM_F_ADDR17, DSM_O_NCH, 8'h00);
        foreach (regs[i]) rd("setup", regs[i]);
        @(negedge clock_i) arm_i = 1'b1;
        @(negedge clock_i) arm_i = 1'b0;
        dsm_ctrl_model_i.issue(DSM_F_WR17, DSM_O_NCH, 8'h04);
        dsm_ctrl_model_i.wait_free(ok);
        check("trig", {1'b1, DSM_TRIG_SOFT}, {ok, cfg_o.trig_src});
        check("near", 16'h012c, cfg_o.near_count);
        check("chans", 3'h1, cfg_o.channels);
        check("seglen", seg_len(regs[10]), cfg_o.seg_len);
        check("segcnt", (regs[11] == 8'h00) ? 8'h01 : regs[11], cfg_o.seg_count);
        check("stop", 1'b1, cfg_o.stop_at_trig);
        check("far", DSM_TB_EXTERNAL, cfg_o.tb_far);
        check("ofs", 8'(regs[1] - DSM_OFS_ZERO), chan_o[0].offset_signed);
        check("src", {regs[5][2:1], regs[5][0]}, {chan_o[0].src, chan_o[0].ac});
        dsm_ctrl_model_i.issue(DSM_F_ADDR17, DSM_O_NCH, 8'h00);
        rd("refused", 8'h01);
        dsm_ctrl_model_i.issue(DSM_F_PREP, DSM_A_DIAG, 8'h00);
        dsm_ctrl_model_i.wait_free(ok);
        check("stat", 2'b11, {ok, status_ok_o});
        dsm_ctrl_model_i.issue(DSM_F_ADDR19, DSM_A_MEMSZ, 8'h00);
        rd("memsz", 8'h00);
        repeat (3) dsm_ctrl_model_i.issue(DSM_F_READ, DSM_A_READ, 8'h00);
        foreach (regs[i]) regs[i] = 8'h00;
        regs[3] = 8'h5a;
        regs[4] = 8'h3c;
        regs[5] = DSM_IRAM_ERR;
        for (int i = 0; i < 6; i++) rd("report", regs[i]);
        dpram_fault_i = 1'b1;
        dsm_ctrl_model_i.issue(DSM_F_PREP, DSM_A_DIAG, 8'h00);
        dsm_ctrl_model_i.wait_free(ok);
        check("fault", 2'b10, {ok, status_ok_o});
        test_done();
    end
endmodule
`default_nettype wire
